//--- bench/testbench.sv
// self-checking apb testbench for the overlay window source register bank
`include "ows_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ows_pkg::ows_vp_in_t vp_in = '0;
  ows_pkg::ows_view_t view;
  logic irq;
  int error_cnt = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic err;
  // documented registers and the bits that read back written ones (base keeps its pending bit too)
  logic [7:0] offs [8] = '{`OWS_OFF_KEYS, `OWS_OFF_KMASK, `OWS_OFF_GBASE, `OWS_OFF_GPITCH,
    `OWS_OFF_W1TL, `OWS_OFF_W1BR, `OWS_OFF_W1BASE, `OWS_OFF_W1PITCH};
  logic [31:0] msks [8] = '{32'h00ff00ff, 32'hffffffff, 32'h000fffff, 32'h03ff03ff,
    32'h07ff07ff, 32'h07ff07ff, 32'h000fffff, 32'h03ff03ff};

  // 20 MHz bus clock
  always #25 pclk = ~pclk;

  ows_regs #(.ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vp_in(vp_in), .view(view), .irq(irq));

  // one apb transfer; waits for pready as long as it takes, the watchdog ends a dead wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp, what);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // software side repack of a true-colour key: top bits of red, green and blue
  function automatic logic [15:0] rgb565(input logic [23:0] c);
    return {c[23:19], c[15:10], c[7:3]};
  endfunction

  // one-cycle frame start pulse, then time for pending, status and view to settle
  task automatic frame();
    @(posedge pclk);
    vp_in.frame_start <= 1'b1;
    @(posedge pclk);
    vp_in.frame_start <= 1'b0;
    cyc(2);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (offs[i]) rdchk(offs[i], 32'h00000000, "reset value");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("test reset done");
    // all ones into each of the eight listed registers: only the documented fields may read them back
    foreach (offs[i]) begin
      apb(1'b1, offs[i], 32'hffffffff);
      rdchk(offs[i], msks[i], "field mask");
    end
    $display("test masks done");
    apb(1'b1, `OWS_OFF_CTRL, 32'h00000001);
    apb(1'b1, `OWS_OFF_KEYS, 32'h12345678);
    rdchk(`OWS_OFF_KEYS, 32'h12345678, "16-bit keys");
    cyc(2);
    chk({view.w2_key, view.w1_key}, 32'h12345678, "16-bit key view");
    apb(1'b1, `OWS_OFF_CTRL, 32'h00000000);
    rdchk(`OWS_OFF_KEYS, 32'h00340078, "8-bit keys");
    cyc(2);
    chk({view.w2_key, view.w1_key}, 32'h00340078, "8-bit key view");
    apb(1'b1, `OWS_OFF_KMASK, 32'ha5a55a5a);
    apb(1'b1, `OWS_OFF_GPITCH, 32'h015502aa);
    apb(1'b1, `OWS_OFF_W1TL, 32'h055502aa);
    apb(1'b1, `OWS_OFF_W1BR, 32'h02aa0555);
    apb(1'b1, `OWS_OFF_W1PITCH, 32'h02aa0155);
    cyc(2);
    chk({view.w2_kmask, view.w1_kmask}, 32'ha5a55a5a, "mask view");
    chk({6'h0, view.gfx_width, 6'h0, view.gfx_offset}, 32'h015502aa, "gfx pitch view");
    chk({5'h0, view.w1_top, 5'h0, view.w1_left}, 32'h055502aa, "top left view");
    chk({5'h0, view.w1_bottom, 5'h0, view.w1_right}, 32'h02aa0555, "bottom right view");
    chk({6'h0, view.w1_width, 6'h0, view.w1_offset}, 32'h02aa0155, "w1 pitch view");
    apb(1'b1, `OWS_OFF_CTRL, 32'h00000002);
    cyc(2);
    chk({31'h0, view.w1_key_enable}, 32'h1, "key enable on");
    apb(1'b1, `OWS_OFF_CTRL, 32'h00000000);
    cyc(2);
    chk({31'h0, view.w1_key_enable}, 32'h0, "key enable off");
    $display("test fields done");
    // new bases with pending set, adopted at the next frame start
    apb(1'b1, `OWS_OFF_GBASE, 32'h00092345);
    apb(1'b1, `OWS_OFF_W1BASE, 32'h000c1234);
    apb(1'b1, `OWS_OFF_IMASK, 32'h00000001);
    rdchk(`OWS_OFF_GBASE, 32'h00092345, "gfx waiting");
    rdchk(`OWS_OFF_W1BASE, 32'h000c1234, "w1 waiting");
    frame();
    chk({13'h0, view.gfx_base}, 32'h00012345, "gfx base view");
    chk({13'h0, view.w1_base}, 32'h00041234, "w1 base view");
    chk({31'h0, irq}, 32'h1, "irq on adoption");
    rdchk(`OWS_OFF_GBASE, 32'h00012345, "gfx adopted");
    rdchk(`OWS_OFF_W1BASE, 32'h00041234, "w1 adopted");
    rdchk(`OWS_OFF_ISTS, 32'h00000003, "both events");
    apb(1'b1, `OWS_OFF_ISTS, 32'h00000001);
    cyc(2);
    chk({31'h0, irq}, 32'h0, "masked event quiet");
    apb(1'b1, `OWS_OFF_IMASK, 32'h00000003);
    cyc(2);
    chk({31'h0, irq}, 32'h1, "unmasked event");
    apb(1'b1, `OWS_OFF_ISTS, 32'h00000002);
    cyc(2);
    chk({31'h0, irq}, 32'h0, "cleared");
    frame();
    rdchk(`OWS_OFF_ISTS, 32'h00000000, "idle frame no event");
    $display("test pending done");
    vp_in.capture_base <= 19'h55555;
    apb(1'b1, `OWS_OFF_CTRL, 32'h00000004);
    cyc(2);
    chk({13'h0, view.w1_base}, 32'h00055555, "follow capture");
    apb(1'b1, `OWS_OFF_CTRL, 32'h00000000);
    cyc(2);
    chk({13'h0, view.w1_base}, 32'h00041234, "own base");
    // true-colour keys go in repacked to 5:6:5, with the bank in 16-bit key mode
    apb(1'b1, `OWS_OFF_CTRL, 32'h00000001);
    apb(1'b1, `OWS_OFF_KEYS, {rgb565(24'h00ff00), rgb565(24'hff8040)});
    rdchk(`OWS_OFF_KEYS, 32'h07e0fc08, "5:6:5 keys");
    cyc(2);
    chk({view.w2_key, view.w1_key}, 32'h07e0fc08, "5:6:5 key view");
    apb(1'b1, 8'h24, 32'hffffffff);
    chk({31'h0, err}, 32'h1, "unmapped write");
    rdchk(8'h24, 32'h00000000, "unmapped read");
    chk({31'h0, err}, 32'h1, "unmapped read error");
    $display("test follow and unmapped done");
    end_sim();
  end
endmodule // testbench

//--- rtl/ows_params.svh
// register offsets, field positions, write masks and reset values of the overlay bank
`ifndef OWS_PARAMS_SVH
`define OWS_PARAMS_SVH
// byte offsets
`define OWS_OFF_KEYS 8'h04
`define OWS_OFF_KMASK 8'h08
`define OWS_OFF_GBASE 8'h0c
`define OWS_OFF_GPITCH 8'h10
`define OWS_OFF_W1TL 8'h14
`define OWS_OFF_W1BR 8'h18
`define OWS_OFF_W1BASE 8'h1c
`define OWS_OFF_W1PITCH 8'h20
`define OWS_OFF_CTRL 8'h40
`define OWS_OFF_ISTS 8'h44
`define OWS_OFF_IMASK 8'h48
// field positions
`define OWS_PEND_BIT 19
`define OWS_HI_LSB 16
`define OWS_CTL_KEY16 0
`define OWS_CTL_KEYEN 1
`define OWS_CTL_FOLLOW 2
`define OWS_EV_GFX 0
`define OWS_EV_W1 1
// writable bits; everything else reads zero, except the pending bit 19 of the base registers, which is outside OWS_M_BASE
`define OWS_M_KEY8 32'h00ff00ff
`define OWS_M_FULL 32'hffffffff
`define OWS_M_BASE 32'h0007ffff
`define OWS_M_PITCH 32'h03ff03ff
`define OWS_M_EDGE 32'h07ff07ff
`define OWS_M_CTRL 32'h00000007
`define OWS_M_EV 32'h00000003
// power-on values are undefined in the device; zero is used here
`define OWS_RST_REG 32'h00000000
`define OWS_RST_BASE 19'h00000
`endif

//--- rtl/ows_pkg.sv
// types shared by the overlay window source register bank
package ows_pkg;
  // configuration handed to the video processor
  typedef struct packed {
    logic [15:0] w2_key;
    logic [15:0] w1_key;
    logic [15:0] w2_kmask;
    logic [15:0] w1_kmask;
    logic w1_key_enable;
    logic [18:0] gfx_base;
    logic [9:0] gfx_width;
    logic [9:0] gfx_offset;
    logic [10:0] w1_top;
    logic [10:0] w1_left;
    logic [10:0] w1_bottom;
    logic [10:0] w1_right;
    logic [18:0] w1_base;
    logic [9:0] w1_width;
    logic [9:0] w1_offset;
  } ows_view_t;
  // events from the video processor
  typedef struct packed {
    logic frame_start;
    logic [18:0] capture_base;
  } ows_vp_in_t;
endpackage

//--- rtl/ows_regs.sv
// overlay colour keys and window source register bank with apb slave
// Function
// R1 - 8-bit mode: keys are index bytes 7:0 and 23:16, rest reserved.
// R2 - 16-bit mode: full 16-bit keys, window II in 31:16, window I in 15:0.
// R3 - software repacks 24/32-bit colour keys to 5:6:5 before writing.
// R4 - key mask register: window II mask 31:16, window I 15:0, 1 enables.
// R5 - graphics source base in bits 18:0, 64-bit segment units.
// R6 - software writes pending bit 19 as 1 with each new base.
// R7 - hardware clears pending once the frame starts using the new base.
// R8 - graphics pending reads 1 until the new base is adopted, else 0.
// R9 - graphics line width in 25:16, bits 31:26 reserved.
// R10 - graphics start offset in 9:0, bits 15:10 reserved.
// R11 - window I top 26:16 and left 10:0, other bits reserved.
// R12 - window I bottom 26:16 and right 10:0, same reserved bits.
// R13 - window I base 18:0 with same pending flag in bit 19.
// R14 - window I pending reads 1 until new base is adopted, else 0.
// R15 - window I line width in 25:16, 64-bit segment units.
// R16 - window I source offset in 9:0, 64-bit segment units.
// R17 - window I keying acts only while its key-enable control is 1.
// R18 - follow-capture at 0 takes window I base from its own register.
// R19 - reserved bits read zero and ignore writes; key upper bytes written in 8-bit mode are still stored.
`include "ows_params.svh"
module ows_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk, // apb clock, 20 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // slave select
  input wire logic penable, // access phase
  input wire logic pwrite, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  output logic [31:0] prdata, // read data
  output logic pready, // transfer done
  output logic pslverr, // unmapped address
  input wire ows_pkg::ows_vp_in_t vp_in, // frame start and capture base
  output ows_pkg::ows_view_t view, // configuration to the video processor
  output logic irq // level interrupt
);

  // offsets are 8 bits wide; a narrower bus cannot reach them
  if (ADDR_W < 8 || ADDR_W > 16) begin : g_bad_addr
    $error("ows_regs: ADDR_W must be 8..16");
  end

  logic [31:0] keys_q, kmask_q, gpitch_q, tl_q, br_q, wpitch_q, ctrl_q;
  logic [18:0] gbase_q, wbase_q, act_gbase_q, act_wbase_q;
  logic gpend_q, wpend_q;
  logic [1:0] ists_q, imask_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  ows_pkg::ows_view_t view_q;
  logic irq_q;

  // address decode
  wire [7:0] off = paddr[7:0];
  wire hi_zero = (paddr >> 8) == '0;
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready_q & pwrite;
  wire hit_keys = hi_zero && off == `OWS_OFF_KEYS;
  wire hit_kmask = hi_zero && off == `OWS_OFF_KMASK;
  wire hit_gbase = hi_zero && off == `OWS_OFF_GBASE;
  wire hit_gpitch = hi_zero && off == `OWS_OFF_GPITCH;
  wire hit_tl = hi_zero && off == `OWS_OFF_W1TL;
  wire hit_br = hi_zero && off == `OWS_OFF_W1BR;
  wire hit_wbase = hi_zero && off == `OWS_OFF_W1BASE;
  wire hit_wpitch = hi_zero && off == `OWS_OFF_W1PITCH;
  wire hit_ctrl = hi_zero && off == `OWS_OFF_CTRL;
  wire hit_ists = hi_zero && off == `OWS_OFF_ISTS;
  wire hit_imask = hi_zero && off == `OWS_OFF_IMASK;
  wire mapped = hit_keys | hit_kmask | hit_gbase | hit_gpitch | hit_tl | hit_br
              | hit_wbase | hit_wpitch | hit_ctrl | hit_ists | hit_imask;

  // mode and control fields
  wire key16 = ctrl_q[`OWS_CTL_KEY16];
  wire key_enable = ctrl_q[`OWS_CTL_KEYEN];
  wire follow = ctrl_q[`OWS_CTL_FOLLOW];
  // in 8-bit mode the upper key bytes are reserved and read zero
  wire [31:0] key_mask = key16 ? `OWS_M_FULL : `OWS_M_KEY8; // R1 R2
  wire [31:0] keys_view = keys_q & key_mask; // R1 R2

  // a pending bit written 1 in the same cycle as a frame start is kept
  wire gset = wr_en & hit_gbase & pwdata[`OWS_PEND_BIT]; // R6
  wire wset = wr_en & hit_wbase & pwdata[`OWS_PEND_BIT]; // R6
  wire gadopt = vp_in.frame_start & gpend_q & ~gset; // R7
  wire wadopt = vp_in.frame_start & wpend_q & ~wset; // R7 R13
  // the two adoption events feed the sticky status register
  wire [1:0] ev = {wadopt, gadopt};

  // read mux; reserved bits come back zero through the store masks, and for the keys through the mode mask
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (1'b1)
      hit_keys: rd_mux = keys_view; // R1 R2
      hit_kmask: rd_mux = kmask_q; // R4
      hit_gbase: rd_mux = {12'h000, gpend_q, gbase_q}; // R5 R8
      hit_gpitch: rd_mux = gpitch_q; // R9 R10
      hit_tl: rd_mux = tl_q; // R11
      hit_br: rd_mux = br_q; // R12
      hit_wbase: rd_mux = {12'h000, wpend_q, wbase_q}; // R13 R14
      hit_wpitch: rd_mux = wpitch_q; // R15 R16
      hit_ctrl: rd_mux = ctrl_q;
      hit_ists: rd_mux = {30'h0, ists_q};
      hit_imask: rd_mux = {30'h0, imask_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // apb answer: registered in setup, so every access has zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `OWS_RST_REG;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // plain storage registers; writes keep only documented bits, except keys, which are stored whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keys_q <= `OWS_RST_REG;
      kmask_q <= `OWS_RST_REG;
      gpitch_q <= `OWS_RST_REG;
      tl_q <= `OWS_RST_REG;
      br_q <= `OWS_RST_REG;
      wpitch_q <= `OWS_RST_REG;
      ctrl_q <= `OWS_RST_REG;
      imask_q <= 2'h0;
    end else if (wr_en) begin
      if (hit_keys) keys_q <= pwdata; // R1 R2
      if (hit_kmask) kmask_q <= pwdata & `OWS_M_FULL; // R4
      if (hit_gpitch) gpitch_q <= pwdata & `OWS_M_PITCH; // R9 R10 R19
      if (hit_tl) tl_q <= pwdata & `OWS_M_EDGE; // R11 R19
      if (hit_br) br_q <= pwdata & `OWS_M_EDGE; // R12 R19
      if (hit_wpitch) wpitch_q <= pwdata & `OWS_M_PITCH; // R15 R16 R19
      if (hit_ctrl) ctrl_q <= pwdata & `OWS_M_CTRL; // R19
      if (hit_imask) imask_q <= pwdata[1:0];
    end
  end

  // source bases and pending flags; set by software beats the frame clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gbase_q <= `OWS_RST_BASE;
      wbase_q <= `OWS_RST_BASE;
      gpend_q <= 1'b0;
      wpend_q <= 1'b0;
    end else begin
      if (wr_en & hit_gbase) gbase_q <= pwdata[18:0]; // R5
      if (wr_en & hit_wbase) wbase_q <= pwdata[18:0]; // R13
      if (wr_en & hit_gbase) gpend_q <= pwdata[`OWS_PEND_BIT]; // R6 R8
      else if (gadopt) gpend_q <= 1'b0; // R7 R8
      if (wr_en & hit_wbase) wpend_q <= pwdata[`OWS_PEND_BIT]; // R6 R14
      else if (wadopt) wpend_q <= 1'b0; // R7 R14
    end
  end

  // bases in use; only a frame start moves them, so a frame never tears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_gbase_q <= `OWS_RST_BASE;
      act_wbase_q <= `OWS_RST_BASE;
    end else begin
      if (gadopt) act_gbase_q <= gbase_q; // R7
      if (wadopt) act_wbase_q <= wbase_q; // R7 R13
    end
  end

  // adoption events: sticky, write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_q <= 2'h0;
    end else begin
      ists_q <= (ists_q & ~((wr_en & hit_ists) ? pwdata[1:0] : 2'h0)) | ev;
    end
  end

  // view to the video processor, registered every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      view_q <= '0;
      irq_q <= 1'b0;
    end else begin
      view_q.w2_key <= keys_view[31:16]; // R1 R2
      view_q.w1_key <= keys_view[15:0]; // R1 R2
      view_q.w2_kmask <= kmask_q[31:16]; // R4
      view_q.w1_kmask <= kmask_q[15:0]; // R4
      view_q.w1_key_enable <= key_enable; // R17
      view_q.gfx_base <= act_gbase_q; // R5
      view_q.gfx_width <= gpitch_q[25:16]; // R9
      view_q.gfx_offset <= gpitch_q[9:0]; // R10
      view_q.w1_top <= tl_q[26:16]; // R11
      view_q.w1_left <= tl_q[10:0]; // R11
      view_q.w1_bottom <= br_q[26:16]; // R12
      view_q.w1_right <= br_q[10:0]; // R12
      // capture follow bypasses the register base entirely
      view_q.w1_base <= follow ? vp_in.capture_base : act_wbase_q; // R18
      view_q.w1_width <= wpitch_q[25:16]; // R15
      view_q.w1_offset <= wpitch_q[9:0]; // R16
      irq_q <= |(ists_q & imask_q);
    end
  end

  // outputs come straight from flip-flops; nothing combinational leaves the bank
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign view = view_q;
  assign irq = irq_q;

  // checks
  // every property samples on pclk and is switched off while reset is low
  sequence s_gwr_pend;
    wr_en && hit_gbase && pwdata[`OWS_PEND_BIT];
  endsequence
  sequence s_frame_g;
    vp_in.frame_start && gpend_q && !(wr_en && hit_gbase);
  endsequence
  sequence s_frame_w;
    vp_in.frame_start && wpend_q && !(wr_en && hit_wbase);
  endsequence

  gpend_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    s_gwr_pend |=> gpend_q) else $error("graphics pending not set by write");
  gpend_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    s_frame_g |=> !gpend_q ##0 act_gbase_q == $past(gbase_q))
    else $error("graphics pending not cleared at frame start");
  gpend_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
    gpend_q && !vp_in.frame_start && !(wr_en && hit_gbase) |=> gpend_q)
    else $error("graphics pending dropped without frame start");
  wpend_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    s_frame_w |=> !wpend_q ##1 (follow || view_q.w1_base == $past(wbase_q, 2)))
    else $error("window pending or base wrong after frame start");
  pitch_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn) // R19
    setup && !pwrite && (hit_gpitch || hit_wpitch)
      |=> (prdata_q & ~`OWS_M_PITCH) == 32'h00000000)
    else $error("reserved pitch bits read nonzero");
  key8_view_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    !key16 ##1 !key16 |-> view_q.w1_key[15:8] == 8'h00 && view_q.w2_key[15:8] == 8'h00)
    else $error("upper key byte visible in 8-bit mode");
  keyen_view_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
    !key_enable |=> !view_q.w1_key_enable) else $error("keying on while disabled");
  follow_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
    !follow |=> view_q.w1_base == $past(act_wbase_q))
    else $error("window base not from own register");
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready_q ##1 !pready_q) else $error("apb answer timing wrong");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    |(ists_q & imask_q) |=> irq_q) else $error("interrupt not raised");

  // the access edge of a write that lands in one register
  sequence s_wr(hit);
    wr_en && hit;
  endsequence
  // the setup cycle of a read; its answer is registered for the access phase
  sequence s_rd(hit);
    setup && !pwrite && hit;
  endsequence

  // keys are stored whole, so a mode change never needs software to rewrite them
  keys_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R1 R2
    s_wr(hit_keys) |=> keys_q == $past(pwdata))
    else $error("key register lost a write");
  key8_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    setup && !pwrite && hit_keys && !key16 |=> (prdata_q & ~`OWS_M_KEY8) == 32'h00000000)
    else $error("reserved key bytes read nonzero in 8-bit mode");
  key16_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    setup && !pwrite && hit_keys && key16 |=> prdata_q == $past(keys_q))
    else $error("16-bit keys read back wrong");
  key16_view_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    key16 ##1 key16 |-> {view_q.w2_key, view_q.w1_key} == $past(keys_q))
    else $error("16-bit keys not shown whole");

  // key masks pass straight through to the keying logic
  kmask_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    s_wr(hit_kmask) |=> kmask_q == $past(pwdata))
    else $error("key mask lost a write");
  kmask_view_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    s_wr(hit_kmask) |-> ##2 {view_q.w2_kmask, view_q.w1_kmask} == $past(pwdata, 2))
    else $error("key mask not shown");

  // graphics base: the store, the read-back with its pending flag, the adoption
  gbase_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
    s_wr(hit_gbase) |=> gbase_q == $past(pwdata[18:0]))
    else $error("graphics base lost a write");
  gbase_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R8 R19
    s_rd(hit_gbase) |=> prdata_q == {12'h000, $past(gpend_q), $past(gbase_q)})
    else $error("graphics base read back wrong");
  gpend_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
    !gpend_q && !(wr_en && hit_gbase) |=> !gpend_q)
    else $error("graphics pending rose without a write");
  gset_wins_a: assert property (@(posedge pclk) disable iff (!presetn) // R6 R7
    gset && vp_in.frame_start |=> gpend_q && act_gbase_q == $past(act_gbase_q))
    else $error("frame start took a base written in the same cycle");
  gbase_view_a: assert property (@(posedge pclk) disable iff (!presetn) // R5 R7
    gadopt |-> ##2 view_q.gfx_base == $past(gbase_q, 2))
    else $error("adopted graphics base not shown");

  // geometry fields keep only their documented bits all the way to the view
  gpitch_view_a: assert property (@(posedge pclk) disable iff (!presetn) // R9 R10 R19
    s_wr(hit_gpitch) |-> ##2
      {6'h00, view_q.gfx_width, 6'h00, view_q.gfx_offset} == ($past(pwdata, 2) & `OWS_M_PITCH))
    else $error("graphics width or offset not shown");
  tl_view_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
    s_wr(hit_tl) |-> ##2
      {5'h00, view_q.w1_top, 5'h00, view_q.w1_left} == ($past(pwdata, 2) & `OWS_M_EDGE))
    else $error("top or left edge not shown");
  br_view_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
    s_wr(hit_br) |-> ##2
      {5'h00, view_q.w1_bottom, 5'h00, view_q.w1_right} == ($past(pwdata, 2) & `OWS_M_EDGE))
    else $error("bottom or right edge not shown");
  wpitch_view_a: assert property (@(posedge pclk) disable iff (!presetn) // R15 R16
    s_wr(hit_wpitch) |-> ##2
      {6'h00, view_q.w1_width, 6'h00, view_q.w1_offset} == ($past(pwdata, 2) & `OWS_M_PITCH))
    else $error("window width or offset not shown");

  // window I base mirrors the graphics base, with its own pending flag
  wbase_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    s_wr(hit_wbase) |=> wbase_q == $past(pwdata[18:0]))
    else $error("window base lost a write");
  wpend_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    wr_en && hit_wbase && pwdata[`OWS_PEND_BIT] |=> wpend_q)
    else $error("window pending not set by write");
  wpend_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    wpend_q && !vp_in.frame_start && !(wr_en && hit_wbase) |=> wpend_q)
    else $error("window pending dropped without frame start");
  wpend_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    !wpend_q && !(wr_en && hit_wbase) |=> !wpend_q)
    else $error("window pending rose without a write");
  wbase_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R14 R19
    s_rd(hit_wbase) |=> prdata_q == {12'h000, $past(wpend_q), $past(wbase_q)})
    else $error("window base read back wrong");
  wbase_act_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    wadopt |=> act_wbase_q == $past(wbase_q))
    else $error("window base not adopted at frame start");

  // control bits act on the view one cycle after they are written
  ctrl_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R19
    s_wr(hit_ctrl) |=> ctrl_q == ($past(pwdata) & `OWS_M_CTRL))
    else $error("control register kept undefined bits");
  keyen_on_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
    key_enable |=> view_q.w1_key_enable)
    else $error("keying off while enabled");
  follow_on_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
    follow |=> view_q.w1_base == $past(vp_in.capture_base))
    else $error("window base not from capture while following");

  // bus side: unmapped writes are dropped, answers are zero outside a read
  unmapped_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // R19
    wr_en && !mapped |=> {keys_q, kmask_q, ctrl_q} == $past({keys_q, kmask_q, ctrl_q}))
    else $error("unmapped write changed a register");
  slverr_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> pslverr_q && pready_q)
    else $error("unmapped access not flagged");
  rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(setup && !pwrite) |=> prdata_q == 32'h00000000)
    else $error("read data nonzero outside a read");

  // event status: a new event is never lost to a clear in the same cycle
  ev_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev != 2'h0 |=> (ists_q & $past(ev)) == $past(ev))
    else $error("adoption event lost");
  ists_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit_ists && ev == 2'h0 |=> (ists_q & $past(pwdata[1:0])) == 2'h0)
    else $error("status bit not cleared by writing one");
  irq_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ists_q & imask_q) == 2'h0 |=> !irq_q)
    else $error("interrupt high with no unmasked event");

endmodule // ows_regs
